//--- design/sfm_pkg.sv
// shared constants, register map and types of the supply fault manager
package sfm_pkg;

  // ************************************************************
  // register map (byte addresses, one word each)
  // ************************************************************
  localparam logic [7:0] SFM_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] SFM_ADDR_STATUS   = 8'h04;
  localparam logic [7:0] SFM_ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] SFM_ADDR_IRQ_CLR  = 8'h0c;
  localparam logic [7:0] SFM_ADDR_IRQ_EN   = 8'h10;
  localparam logic [2:0] SFM_HSIZE_WORD    = 3'h2;

  // control register fields
  localparam int SFM_CTRL_CLR    = 0;
  localparam int SFM_CTRL_DIS_UV = 1;
  localparam int SFM_CTRL_DIS_OV = 2;
  localparam int SFM_CTRL_MODE   = 3;
  localparam int SFM_CTRL_MODE_W = 2;

  // status register fields (flags in bits 5:0)
  localparam int SFM_NFLAG    = 6;
  localparam int SFM_FL_SUM   = 0;
  localparam int SFM_FL_UNDER = 1;
  localparam int SFM_FL_OVER  = 2;
  localparam int SFM_FL_SD    = 3;
  localparam int SFM_FL_SH    = 4;
  localparam int SFM_FL_GV    = 5;
  localparam int SFM_ST_PIN   = 8;
  localparam int SFM_ST_BLOCK = 9;
  localparam int SFM_ST_SHUT  = 10;
  localparam int SFM_ST_OCST  = 12;

  // interrupt events
  localparam int SFM_NIRQ        = 3;
  localparam int SFM_IRQ_ASSERT  = 0;
  localparam int SFM_IRQ_RELEASE = 1;
  localparam int SFM_IRQ_WAKE    = 2;

  // synchroniser vector positions
  localparam int SFM_NSYNC = 10;
  localparam int SFM_S_RAILS = 0;
  localparam int SFM_S_DRH   = 1;
  localparam int SFM_S_GV    = 2;
  localparam int SFM_S_SH    = 3;
  localparam int SFM_S_SD    = 4;
  localparam int SFM_S_OVER  = 5;
  localparam int SFM_S_UNDER = 6;
  localparam int SFM_S_CORE  = 7;
  localparam int SFM_S_EN    = 8;
  localparam int SFM_S_PIN   = 9;

  // retry delay default in cycles, free value
  localparam logic [31:0] SFM_RETRY_CYCLES_DEF = 32'h0007_a120;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    SFM_MODE_LATCH   = 2'b00,
    SFM_MODE_RETRY   = 2'b01,
    SFM_MODE_REPORT  = 2'b10,
    SFM_MODE_DISABLE = 2'b11
  } sfm_oc_mode_t;

  typedef enum logic [1:0] {
    SFM_OC_IDLE   = 2'b00,
    SFM_OC_LATCH  = 2'b01,
    SFM_OC_REPORT = 2'b10,
    SFM_OC_RETRY  = 2'b11
  } sfm_oc_state_t;

  typedef struct packed {
    logic core_supply_low;
    logic supply_under;
    logic supply_over;
    logic switch_drop_overcurrent;
    logic shunt_overcurrent;
    logic gate_voltage_fault;
    logic drive_rail_high;
    logic rails_started;
  } sfm_fault_in_t;

  typedef struct packed {
    logic shutdown;
    logic gate_block;
    logic buck_en;
    logic pump_en;
    logic core_reg_en;
    logic always_on_reg_en;
    logic host_reg_en;
  } sfm_rail_out_t;

  typedef struct packed {
    logic [SFM_NSYNC-1:0] sync1;
    logic [SFM_NSYNC-1:0] sync2;
    logic                 en_prev;
    logic                 dis_uv;
    logic                 dis_ov;
    sfm_oc_mode_t         oc_mode;
    logic                 clr_pulse;
    logic [SFM_NFLAG-1:0] flags;
    logic                 ov_lock;
    sfm_oc_state_t        oc_state;
    logic [31:0]          retry_cnt;
    logic [SFM_NIRQ-1:0]  irq_stat;
    logic [SFM_NIRQ-1:0]  irq_en;
    logic                 dp_valid;
    logic                 dp_write;
    logic [7:0]           dp_addr;
    logic [31:0]          hrdata;
    logic                 pin_low;
    sfm_rail_out_t        rails;
  } sfm_state_t;

  localparam sfm_rail_out_t SFM_RAILS_RST = '{shutdown: 1'b0, gate_block: 1'b1, buck_en: 1'b0,
                                              pump_en: 1'b0, core_reg_en: 1'b0,
                                              always_on_reg_en: 1'b1, host_reg_en: 1'b1};
  // enable synchroniser and edge history start at the idle high level, so no false clear follows reset
  localparam sfm_state_t SFM_STATE_RST = '{sync1: 10'h100, sync2: 10'h100, en_prev: 1'b1,
                                           oc_mode: SFM_MODE_LATCH, oc_state: SFM_OC_IDLE,
                                           pin_low: 1'b1, rails: SFM_RAILS_RST, default: '0};

endpackage

//--- design/sfm_fault_manager.sv
// supply fault manager: fault indicator, latched flags, recovery and ahb-lite registers
`timescale 1ns/1ns

module sfm_fault_manager
  import sfm_pkg::*;
#(
  parameter logic [31:0] RETRY_CYCLES = SFM_RETRY_CYCLES_DEF
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire sfm_fault_in_t fault_in,
  input  wire logic          enable_pin,
  input  wire logic          fault_out_n_i,
  output logic               fault_out_n_o,
  output logic               fault_out_n_oe,
  output sfm_rail_out_t      rails,
  output logic               irq
);

  // ************************************************************
  // parameter check
  // ************************************************************
  if (RETRY_CYCLES < 32'h1) begin : g_bad_retry
    $error("retry delay must be at least one cycle");
  end

  // ************************************************************
  // state
  // ************************************************************
  sfm_state_t r;
  sfm_state_t n;

  logic [SFM_NSYNC-1:0] s;
  logic                 en_rise;
  logic                 clear;
  logic                 sd_ev;
  logic                 sh_ev;
  logic                 oc_ev;
  logic                 gv_ev;
  logic                 oc_cond;
  logic                 retry_done;
  logic                 uv_act;
  logic                 ov_act;
  logic                 addr_ok;
  logic                 wr_hit;
  logic [SFM_NIRQ-1:0]  irq_ev;
  logic [SFM_NIRQ-1:0]  irq_clr;
  logic [31:0]          rd_mux;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    n = r;
    // two-flop synchronisers on every pin and comparator input
    n.sync1 = {fault_out_n_i, enable_pin, fault_in};
    n.sync2 = r.sync1;
    s = r.sync2;

    // clear source: enable low pulse ending, or command pulse
    en_rise   = s[SFM_S_EN] & ~r.en_prev;
    n.en_prev = s[SFM_S_EN];
    clear     = r.clr_pulse | en_rise;
    n.clr_pulse = 1'b0;

    // overcurrent and gate-voltage events
    sd_ev   = s[SFM_S_SD] & (r.oc_mode != SFM_MODE_DISABLE);
    sh_ev   = s[SFM_S_SH] & (r.oc_mode != SFM_MODE_DISABLE);
    oc_ev   = sd_ev | sh_ev;
    gv_ev   = s[SFM_S_GV];
    oc_cond = oc_ev | gv_ev;
    retry_done = (r.oc_state == SFM_OC_RETRY) && (r.retry_cnt == RETRY_CYCLES - 32'h1);

    // overcurrent recovery state machine
    case (r.oc_state)
      SFM_OC_IDLE: begin
        if (gv_ev || (oc_ev && r.oc_mode == SFM_MODE_LATCH)) begin
          n.oc_state = SFM_OC_LATCH;
        end else if (oc_ev && r.oc_mode == SFM_MODE_RETRY) begin
          n.oc_state  = SFM_OC_RETRY;
          n.retry_cnt = 32'h0;
        end else if (oc_ev && r.oc_mode == SFM_MODE_REPORT) begin
          n.oc_state = SFM_OC_REPORT;
        end
      end
      SFM_OC_LATCH: begin
        if (clear && !oc_cond) begin
          n.oc_state = SFM_OC_IDLE;
        end
      end
      SFM_OC_REPORT: begin
        if (gv_ev || (oc_ev && r.oc_mode == SFM_MODE_LATCH)) begin
          n.oc_state = SFM_OC_LATCH;
        end else if (clear && !oc_cond) begin
          n.oc_state = SFM_OC_IDLE;
        end
      end
      SFM_OC_RETRY: begin
        if (gv_ev) begin
          n.oc_state = SFM_OC_LATCH;
        end else if (retry_done) begin
          n.oc_state  = SFM_OC_IDLE;
          n.retry_cnt = 32'h0;
        end else begin
          n.retry_cnt = r.retry_cnt + 32'h1;
        end
      end
      default: begin
        n.oc_state = SFM_OC_IDLE;
      end
    endcase

    // sticky flags, a setting event wins over a clear in the same cycle
    n.flags[SFM_FL_UNDER] = s[SFM_S_UNDER] | (r.flags[SFM_FL_UNDER] & ~clear);
    n.flags[SFM_FL_OVER]  = s[SFM_S_OVER] | (r.flags[SFM_FL_OVER] & ~clear);
    n.flags[SFM_FL_SD]    = sd_ev | (r.flags[SFM_FL_SD] & ~clear & ~retry_done);
    n.flags[SFM_FL_SH]    = sh_ev | (r.flags[SFM_FL_SH] & ~clear & ~retry_done);
    n.flags[SFM_FL_GV]    = gv_ev | (r.flags[SFM_FL_GV] & ~clear);
    n.flags[SFM_FL_SUM]   = |n.flags[SFM_NFLAG-1:1];

    // gate lock after supply high, released only by clear
    n.ov_lock = (s[SFM_S_OVER] & ~r.dis_ov) | (r.ov_lock & ~clear);

    // power and gate response
    uv_act = s[SFM_S_UNDER] & ~r.dis_uv;
    ov_act = s[SFM_S_OVER] & ~r.dis_ov;
    n.rails.shutdown         = s[SFM_S_CORE];
    n.rails.always_on_reg_en = 1'b1;
    n.rails.host_reg_en      = 1'b1;
    n.rails.core_reg_en      = ~(s[SFM_S_CORE] | uv_act | ov_act);
    n.rails.buck_en          = ~(s[SFM_S_CORE] | uv_act | ov_act | s[SFM_S_DRH]);
    n.rails.pump_en          = ~(s[SFM_S_CORE] | uv_act | ov_act | s[SFM_S_DRH]);
    n.rails.gate_block       = s[SFM_S_CORE] | uv_act | ov_act | n.ov_lock | s[SFM_S_DRH]
                               | (n.oc_state == SFM_OC_LATCH) | (n.oc_state == SFM_OC_RETRY);

    // fault pin: core low, under, over or drive-rail fault present, overcurrent state other than idle, or rails not up
    n.pin_low = s[SFM_S_CORE] | s[SFM_S_UNDER] | s[SFM_S_OVER] | s[SFM_S_DRH]
                | ~s[SFM_S_RAILS] | (n.oc_state != SFM_OC_IDLE);

    // ahb-lite data phase: register writes
    addr_ok = (r.dp_addr[1:0] == 2'b00);
    wr_hit  = r.dp_valid & r.dp_write & addr_ok;
    irq_clr = '0;
    if (wr_hit) begin
      case (r.dp_addr)
        SFM_ADDR_CTRL: begin
          n.clr_pulse = hwdata[SFM_CTRL_CLR];
          n.dis_uv    = hwdata[SFM_CTRL_DIS_UV];
          n.dis_ov    = hwdata[SFM_CTRL_DIS_OV];
          n.oc_mode   = sfm_oc_mode_t'(hwdata[SFM_CTRL_MODE +: SFM_CTRL_MODE_W]);
        end
        SFM_ADDR_IRQ_CLR: begin
          irq_clr = hwdata[SFM_NIRQ-1:0];
        end
        SFM_ADDR_IRQ_EN: begin
          n.irq_en = hwdata[SFM_NIRQ-1:0];
        end
        default: begin
        end
      endcase
    end

    // interrupt events: pin asserted, pin released, shutdown left
    irq_ev[SFM_IRQ_ASSERT]  = n.pin_low & ~r.pin_low;
    irq_ev[SFM_IRQ_RELEASE] = ~n.pin_low & r.pin_low;
    irq_ev[SFM_IRQ_WAKE]    = r.rails.shutdown & ~n.rails.shutdown;
    n.irq_stat = irq_ev | (r.irq_stat & ~irq_clr);

    // ahb-lite address phase: capture, read data from post-write state
    n.dp_valid = hsel & htrans[1] & hready;
    n.dp_write = hwrite & (hsize == SFM_HSIZE_WORD);
    n.dp_addr  = haddr[7:0];
    rd_mux = '0;
    case (haddr[7:0])
      SFM_ADDR_CTRL: begin
        rd_mux[SFM_CTRL_DIS_UV] = n.dis_uv;
        rd_mux[SFM_CTRL_DIS_OV] = n.dis_ov;
        rd_mux[SFM_CTRL_MODE +: SFM_CTRL_MODE_W] = n.oc_mode;
      end
      SFM_ADDR_STATUS: begin
        rd_mux[SFM_NFLAG-1:0]             = n.flags;
        rd_mux[SFM_ST_PIN]                = s[SFM_S_PIN];
        rd_mux[SFM_ST_BLOCK]              = n.rails.gate_block;
        rd_mux[SFM_ST_SHUT]               = n.rails.shutdown;
        rd_mux[SFM_ST_OCST +: 2]          = n.oc_state;
      end
      SFM_ADDR_IRQ_STAT: begin
        rd_mux[SFM_NIRQ-1:0] = n.irq_stat;
      end
      SFM_ADDR_IRQ_EN: begin
        rd_mux[SFM_NIRQ-1:0] = n.irq_en;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
    if (n.dp_valid && !hwrite) begin
      n.hrdata = rd_mux;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= SFM_STATE_RST;
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign hrdata         = r.hrdata;
  assign hreadyout      = 1'b1;  // zero wait states
  assign hresp          = 1'b0;  // always okay
  assign fault_out_n_o  = 1'b0;  // open drain, only ever pulls low
  assign fault_out_n_oe = r.pin_low;
  assign rails          = r.rails;
  assign irq            = |(r.irq_stat & r.irq_en);

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_latched;
    r.oc_state == SFM_OC_LATCH;
  endsequence

  sequence seq_release_req;
    clear && !oc_cond;
  endsequence

  sequence seq_retry_end;
    r.oc_state == SFM_OC_RETRY && r.retry_cnt == RETRY_CYCLES - 32'h1 && !gv_ev;
  endsequence

  chk_core_pin_low: assert property (s[SFM_S_CORE] |=> fault_out_n_oe && rails.shutdown)
    else $error("core supply low did not pull fault pin");

  chk_rails_hold_pin: assert property (!s[SFM_S_RAILS] |=> fault_out_n_oe)
    else $error("fault pin released before rail start-up");

  chk_latch_stays: assert property (seq_latched ##0 !clear |=> fault_out_n_oe ##0 seq_latched)
    else $error("latched overcurrent released without clear");

  chk_clear_release: assert property (seq_latched ##0 seq_release_req |=> r.oc_state == SFM_OC_IDLE)
    else $error("clear did not release latched fault");

  chk_flag_clear: assert property (clear && !s[SFM_S_UNDER] |=> !r.flags[SFM_FL_UNDER])
    else $error("under flag survived clear");

  chk_shutdown_rails: assert property (s[SFM_S_CORE] |=> rails.gate_block && !rails.buck_en
                                       && !rails.pump_en && !rails.core_reg_en && rails.host_reg_en)
    else $error("shutdown rail state wrong");

  chk_sleep_exit: assert property (rails.shutdown && !s[SFM_S_CORE] |=> !rails.shutdown)
    else $error("shutdown not left after core supply recovery");

  chk_under_block: assert property (s[SFM_S_UNDER] && !r.dis_uv |=> rails.gate_block && !rails.core_reg_en
                                    && r.flags[SFM_FL_UNDER] && r.flags[SFM_FL_SUM])
    else $error("supply low response wrong");

  chk_under_sticky: assert property (r.flags[SFM_FL_UNDER] && !clear |=> r.flags[SFM_FL_UNDER])
    else $error("under flag cleared without clear");

  chk_under_report: assert property (s[SFM_S_UNDER] && r.dis_uv && !s[SFM_S_CORE] && !s[SFM_S_OVER]
                                     && !s[SFM_S_DRH] |=> rails.core_reg_en && fault_out_n_oe)
    else $error("disabled supply low changed operation");

  chk_over_lock: assert property (r.ov_lock && !clear |=> r.ov_lock && rails.gate_block)
    else $error("gates unblocked after supply high without clear");

  chk_over_flag: assert property (s[SFM_S_OVER] |=> r.flags[SFM_FL_OVER] && fault_out_n_oe)
    else $error("supply high not flagged");

  chk_over_clear: assert property (r.ov_lock && clear && !s[SFM_S_OVER] |=> !r.ov_lock)
    else $error("clear did not release supply high lock");

  chk_drive_rail: assert property (s[SFM_S_DRH] ##1 !s[SFM_S_DRH] && !s[SFM_S_CORE] && !uv_act
                                   && !ov_act |=> rails.buck_en && rails.pump_en)
    else $error("pump and buck did not resume");

  chk_retry_end: assert property (seq_retry_end |=> r.oc_state == SFM_OC_IDLE && r.retry_cnt == 32'h0)
    else $error("retry did not restart on time");

  chk_clear_pulse: assert property (r.clr_pulse |=> !r.clr_pulse || $past(wr_hit))
    else $error("clear command did not self clear");

  chk_sync_depth: assert property (s[SFM_S_UNDER] == $past(fault_in.supply_under, 2))
    else $error("synchroniser depth wrong");

endmodule

//--- test/sfm_host_model.sv
// host controller model: watches the fault pin and pulses the enable pin
`timescale 1ns/1ns

module sfm_host_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic fault_wire,
  input  wire logic pulse_req,
  output logic      enable_pin,
  output logic      motor_run
);
  logic [2:0] low_cnt;

  // four-cycle enable low pulse on request, then back high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt    <= 3'h0;
      enable_pin <= 1'b1;
    end else if (pulse_req && low_cnt == 3'h0) begin
      low_cnt    <= 3'h4;
      enable_pin <= 1'b0;
    end else if (low_cnt != 3'h0) begin
      low_cnt    <= low_cnt - 3'h1;
      enable_pin <= (low_cnt == 3'h1);
    end
  end

  // motor control halts while the pin is low, resumes on release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) motor_run <= 1'b0;
    else motor_run <= fault_wire;
  end
endmodule

//--- test/tb_top.sv
// self-checking testbench of the supply fault manager
`timescale 1ns/1ns

module tb_top
  import sfm_pkg::*;
;
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  sfm_fault_in_t fault_in;
  sfm_rail_out_t rails;
  logic          pin_o, oe, fault_wire, enable_pin, pulse_req, motor_run;
  int            n_mismatch, samples_checked, cycles;

  // pull-up on the open-drain fault wire
  assign fault_wire = oe ? pin_o : 1'b1;

  sfm_fault_manager #(.RETRY_CYCLES(32'h10)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in), .enable_pin(enable_pin),
    .fault_out_n_i(fault_wire), .fault_out_n_o(pin_o), .fault_out_n_oe(oe), .rails(rails), .irq(irq));

  sfm_host_model host (
    .hclk(hclk), .hresetn(hresetn), .fault_wire(fault_wire), .pulse_req(pulse_req),
    .enable_pin(enable_pin), .motor_run(motor_run));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic results();
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // one ahb-lite single word transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge hclk);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    cmp(what, exp, v & mask);
  endtask

  task automatic set_in(input int bit_no, input logic v);
    @(posedge hclk);
    fault_in[bit_no] <= v;
  endtask

  task automatic pulse_en();
    @(posedge hclk);
    pulse_req <= 1'b1;
    @(posedge hclk);
    pulse_req <= 1'b0;
    tick(12);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    tick(1);
    cmp_bit("pin_drive", 1'b1, oe);
    cmp_bit("hresp", 1'b0, hresp);
    rd_chk("ctrl", SFM_ADDR_CTRL, 32'hffff_ffff, 32'h0);
    rd_chk("irq_en", SFM_ADDR_IRQ_EN, 32'hffff_ffff, 32'h0);
    rd_chk("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
    set_in(0, 1'b1);
    tick(8);
    cmp_bit("pin_drive", 1'b0, oe);
    cmp("rails", 32'h1f, 32'(rails));
    cmp_bit("motor_run", 1'b1, motor_run);
    wr(SFM_ADDR_IRQ_CLR, 32'h7);
  endtask

  // switch-drop, shunt and gate-voltage faults keep the pin low until cleared
  task automatic t_latched();
    for (int i = 0; i < 3; i++) begin
      set_in(4 - i, 1'b1);
      tick(2);
      cmp_bit("pin_drive", 1'b0, oe);
      tick(1);
      cmp_bit("pin_drive", 1'b1, oe);
      cmp_bit("gate_block", 1'b1, rails.gate_block);
      wr(SFM_ADDR_CTRL, 32'h1);
      tick(4);
      cmp_bit("pin_drive", 1'b1, oe);
      set_in(4 - i, 1'b0);
      tick(6);
      cmp_bit("pin_drive", 1'b1, oe);
      rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h1 | (32'h1 << (3 + i)));
      if (i == 1) begin
        pulse_en();
      end else begin
        wr(SFM_ADDR_CTRL, 32'h1);
      end
      tick(4);
      cmp_bit("pin_drive", 1'b0, oe);
      cmp_bit("gate_block", 1'b0, rails.gate_block);
      rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h0);
      rd_chk("ctrl", SFM_ADDR_CTRL, 32'h1, 32'h0);
    end
  endtask

  task automatic t_supply();
    set_in(6, 1'b1);
    tick(4);
    cmp_bit("pin_drive", 1'b1, oe);
    cmp("rails", 32'h23, 32'(rails));
    set_in(6, 1'b0);
    tick(4);
    cmp_bit("pin_drive", 1'b0, oe);
    cmp("rails", 32'h1f, 32'(rails));
    rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h3);
    pulse_en();
    rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h0);
    set_in(5, 1'b1);
    tick(4);
    cmp_bit("pin_drive", 1'b1, oe);
    cmp("rails", 32'h23, 32'(rails));
    set_in(5, 1'b0);
    tick(4);
    cmp_bit("pin_drive", 1'b0, oe);
    cmp("rails", 32'h3f, 32'(rails));
    rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h5);
    wr(SFM_ADDR_CTRL, 32'h1);
    tick(4);
    cmp("rails", 32'h1f, 32'(rails));
    rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h0);
  endtask

  // detection off: only the pin and the flags react
  task automatic t_detect_off();
    wr(SFM_ADDR_CTRL, 32'h6);
    for (int j = 0; j < 2; j++) begin
      set_in(6 - j, 1'b1);
      tick(4);
      cmp_bit("pin_drive", 1'b1, oe);
      cmp("rails", 32'h1f, 32'(rails));
      set_in(6 - j, 1'b0);
      tick(4);
      cmp_bit("pin_drive", 1'b0, oe);
      rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h1 | (32'h2 << j));
      wr(SFM_ADDR_CTRL, 32'h7);
      rd_chk("status", SFM_ADDR_STATUS, 32'h3f, 32'h0);
    end
    wr(SFM_ADDR_CTRL, 32'h0);
  endtask

  task automatic t_core_retry();
    int n;
    set_in(7, 1'b1);
    tick(4);
    cmp("rails", 32'h63, 32'(rails));
    set_in(7, 1'b0);
    tick(6);
    cmp_bit("shutdown", 1'b0, rails.shutdown);
    cmp_bit("pin_drive", 1'b0, oe);
    rd_chk("irq_wake", SFM_ADDR_IRQ_STAT, 32'h4, 32'h4);
    wr(SFM_ADDR_CTRL, 32'h8);
    set_in(4, 1'b1);
    set_in(4, 1'b0);
    tick(5);
    cmp_bit("pin_drive", 1'b1, oe);
    n = 0;
    while (oe !== 1'b0 && n < 60) begin
      tick(1);
      n++;
    end
    cmp_bit("retry_release", 1'b0, oe);
    cmp_bit("gate_block", 1'b0, rails.gate_block);
    wr(SFM_ADDR_CTRL, 32'h0);
  endtask

  // drive rail high with the pin-asserted interrupt raised, masked and cleared
  task automatic t_rail_irq();
    wr(SFM_ADDR_IRQ_CLR, 32'h7);
    wr(SFM_ADDR_IRQ_EN, 32'h1);
    set_in(1, 1'b1);
    tick(4);
    cmp_bit("pin_drive", 1'b1, oe);
    cmp_bit("pump_en", 1'b0, rails.pump_en);
    cmp_bit("irq", 1'b1, irq);
    wr(SFM_ADDR_IRQ_EN, 32'h0);
    tick(1);
    cmp_bit("irq", 1'b0, irq);
    wr(SFM_ADDR_IRQ_EN, 32'h1);
    tick(1);
    cmp_bit("irq", 1'b1, irq);
    set_in(1, 1'b0);
    tick(4);
    cmp_bit("pump_en", 1'b1, rails.pump_en);
    cmp_bit("buck_en", 1'b1, rails.buck_en);
    cmp_bit("pin_drive", 1'b0, oe);
    wr(SFM_ADDR_IRQ_CLR, 32'h7);
    tick(1);
    cmp_bit("irq", 1'b0, irq);
    rd_chk("irq_stat", SFM_ADDR_IRQ_STAT, 32'h1, 32'h0);
  endtask

  // ************************************************************
  // clock, timeout and main sequence
  // ************************************************************
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    hresetn   = 1'b0;
    hsel      = 1'b1;
    haddr     = 32'h0;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = SFM_HSIZE_WORD;
    hwdata    = 32'h0;
    fault_in  = '0;
    pulse_req = 1'b0;
    repeat (7) @(posedge hclk);
    #1;
    cmp("rails", 32'h23, 32'(rails));
    @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_latched();
    t_supply();
    t_detect_off();
    t_core_retry();
    t_rail_irq();
    results();
  end
endmodule
